// ===== hdl/vco_calibration_control.sv
// Purpose: staged control registers and trigger of the oscillator calibration
// Assumes: register writes arrive decoded from the serial control port
// Notes: reads return the staged copy one cycle after rd_en
`timescale 1ns/100ps
module vco_calibration_control
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic wr_en,
	input wire logic [9:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic rd_en,
	input wire logic [9:0] rd_addr,
	input wire logic io_update,
	output logic [7:0] rd_data,
	output logic [7:0] cal_ctrl_active,
	output logic [7:0] dly_ctrl_active,
	output logic cal_busy,
	output logic cal_done,
	output logic cal_clk
);
	typedef enum logic {ST_IDLE, ST_RUN} cal_state_e;

	typedef struct packed
	{
		logic [7:0] cal_stage;
		logic [7:0] dly_stage;
		logic [7:0] cal_act;
		logic [7:0] dly_act;
		logic [7:0] rd_data;
		cal_state_e state;
		logic [15:0] ticks;
		logic busy;
		logic done;
	} ctrl_s;

	ctrl_s s_q;
	ctrl_s s_d;
	logic tick;
	logic [1:0] act_sel;
	logic edge_seen;

	assign act_sel = s_q.cal_act[vco_cal_pkg::DIV_LSB +: 2];

	// ----------------------------------------
	// calibration clock
	// ----------------------------------------
	// divider runs only during a calibration so every run starts phase-aligned;
	// it follows the next busy value so the run lasts exactly CAL_TICKS periods
	cal_clock_divider u_div
	(
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.run(s_d.busy),
		.sel(act_sel),
		.tick(tick),
		.cal_clk(cal_clk)
	);

	// new staged trigger against the value held since the previous strobe
	assign edge_seen = io_update && s_q.cal_stage[vco_cal_pkg::TRIG_BIT]
		&& !s_q.cal_act[vco_cal_pkg::TRIG_BIT];

	// ----------------------------------------
	// registers and sequencer
	// ----------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		// host writes land in the staging copy only
		if (wr_en && wr_addr == vco_cal_pkg::ADDR_CAL_CTRL)
			s_d.cal_stage = wr_data;
		if (wr_en && wr_addr == vco_cal_pkg::ADDR_DLY_CTRL)
			s_d.dly_stage = wr_data;
		// unmapped addresses read as zero
		if (rd_en)
		begin
			if (rd_addr == vco_cal_pkg::ADDR_CAL_CTRL)
				s_d.rd_data = s_q.cal_stage;
			else if (rd_addr == vco_cal_pkg::ADDR_DLY_CTRL)
				s_d.rd_data = s_q.dly_stage;
			else
				s_d.rd_data = 8'h00;
		end
		// transfer strobe copies staged values active
		if (io_update)
		begin
			s_d.cal_act = s_q.cal_stage;
			s_d.dly_act = s_q.dly_stage;
		end
		unique case (s_q.state)
			ST_IDLE:
			begin
				// only a 0-to-1 change starts; a held 1 does nothing
				if (edge_seen)
				begin
					s_d.state = ST_RUN;
					s_d.busy = 1'b1;
					s_d.ticks = 16'h0000;
				end
			end
			ST_RUN:
			begin
				// one sequence timed by the divided clock; edges during it are
				// absorbed, but a transfer strobe still copies a new ratio into cal_act mid-run
				if (tick)
				begin
					s_d.ticks = s_q.ticks + 16'h0001;
					if (s_d.ticks == vco_cal_pkg::CAL_TICKS)
					begin
						s_d.state = ST_IDLE;
						s_d.busy = 1'b0;
						s_d.done = 1'b1;
					end
				end
			end
		endcase
	end

	// trigger bit resets to 0, ratio to divide-by-16
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_q <= '0;
			s_q.cal_stage <= vco_cal_pkg::CAL_CTRL_RESET;
			s_q.cal_act <= vco_cal_pkg::CAL_CTRL_RESET;
			s_q.dly_stage <= vco_cal_pkg::DLY_CTRL_RESET;
			s_q.dly_act <= vco_cal_pkg::DLY_CTRL_RESET;
			s_q.state <= ST_IDLE;
		end
		else
			s_q <= s_d;
	end

	assign rd_data = s_q.rd_data;
	assign cal_ctrl_active = s_q.cal_act;
	assign dly_ctrl_active = s_q.dly_act;
	assign cal_busy = s_q.busy;
	assign cal_done = s_q.done;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	logic [23:0] dur_q;
	logic first_q;

	// reference cycles in one divided period
	function automatic logic [4:0] div_len(input logic [1:0] sel);
		div_len = {1'b0, vco_cal_pkg::div_last(sel)} + 5'h01;
	endfunction

	// helper: reference cycles spent in the current calibration
	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dur_q <= 24'h000000;
			first_q <= 1'b1;
		end
		else
		begin
			dur_q <= s_q.busy ? dur_q + 24'h000001 : 24'h000000;
			first_q <= 1'b0;
		end
	end

	sequence s_arm;
		io_update && s_q.cal_stage[0] && !s_q.cal_act[0] && s_q.state == ST_IDLE;
	endsequence

	property p_start_edge;
		@(posedge clk_sys) disable iff (!arst_n)
		$rose(s_q.busy) |-> $past(io_update) && !$past(s_q.cal_act[0]) && s_q.cal_act[0];
	endproperty
	a_start_edge: assert property (p_start_edge) else $error("start without edge");

	property p_held_one;
		@(posedge clk_sys) disable iff (!arst_n)
		io_update && s_q.cal_act[0] && s_q.state == ST_IDLE |=> !s_q.busy;
	endproperty
	a_held_one: assert property (p_held_one) else $error("held bit restarted");

	property p_arm_starts;
		@(posedge clk_sys) disable iff (!arst_n)
		s_arm |=> s_q.busy && s_q.cal_act[0];
	endproperty
	a_arm_starts: assert property (p_arm_starts) else $error("edge missed");

	property p_staged_only;
		@(posedge clk_sys) disable iff (!arst_n)
		!io_update |=> $stable(s_q.cal_act) && $stable(s_q.dly_act);
	endproperty
	a_staged_only: assert property (p_staged_only) else $error("active changed");

	property p_duration;
		@(posedge clk_sys) disable iff (!arst_n)
		$rose(s_q.done) |->
			dur_q == 24'(vco_cal_pkg::CAL_TICKS) * 24'(div_len(act_sel));
	endproperty
	a_duration: assert property (p_duration) else $error("calibration length wrong");

	property p_reset_zero;
		@(posedge clk_sys) disable iff (!arst_n)
		first_q |-> !s_q.cal_stage[0] && s_q.cal_stage[2:1] == 2'h3;
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("bad reset value");

	property p_done_ends;
		@(posedge clk_sys) disable iff (!arst_n)
		s_q.done |-> !s_q.busy ##1 !s_q.done;
	endproperty
	a_done_ends: assert property (p_done_ends) else $error("done not single");
endmodule

// ===== hdl/vco_cal_pkg.sv
// Purpose: constants for the tunable_oscillator calibration control block
// Assumes: one clock, clk_sys, also serves as the loop reference clock
// Notes: register offsets are word addresses of the serial control port
package vco_cal_pkg;
	localparam logic [9:0] ADDR_CAL_CTRL = 10'h018;
	localparam logic [9:0] ADDR_DLY_CTRL = 10'h019;
	localparam logic [7:0] CAL_CTRL_RESET = 8'h06;
	localparam logic [7:0] DLY_CTRL_RESET = 8'h00;
	localparam int TRIG_BIT = 0;
	localparam int DIV_LSB = 1;
	localparam logic [1:0] DIV_SEL_RESET = 2'h3;
	// length of one calibration in divided clock periods
	localparam logic [15:0] CAL_TICKS = 16'h0040;

	// divide ratio minus one for a 2-bit select code
	function automatic logic [3:0] div_last(input logic [1:0] sel);
		unique case (sel)
			2'h0: div_last = 4'h1;
			2'h1: div_last = 4'h3;
			2'h2: div_last = 4'h7;
			2'h3: div_last = 4'hF;
		endcase
	endfunction
endpackage

// ===== hdl/cal_clock_divider.sv
// Purpose: divides the reference clock into the calibration clock
// Assumes: sel steady while run is high
// Notes: tick pulses once per divided period, registered, in the reference cycle after its last one
`timescale 1ns/100ps
module cal_clock_divider
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic run,
	input wire logic [1:0] sel,
	output logic tick,
	output logic cal_clk
);
	typedef struct packed
	{
		logic [3:0] cnt;
		logic tick;
		logic clk;
	} div_s;

	div_s s_q;
	div_s s_d;

	// ----------------------------------------
	// divider counter
	// ----------------------------------------
	// ratio picked by the select code
	always_comb
	begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!run)
		begin
			s_d.cnt = 4'h0;
			s_d.clk = 1'b0;
		end
		else if (s_q.cnt == vco_cal_pkg::div_last(sel))
		begin
			s_d.cnt = 4'h0;
			s_d.tick = 1'b1;
			s_d.clk = 1'b0;
		end
		else
		begin
			s_d.cnt = s_q.cnt + 4'h1;
			// high for the second half of the period
			s_d.clk = (s_d.cnt > (vco_cal_pkg::div_last(sel) >> 1));
		end
	end

	always_ff @(posedge clk_sys or negedge arst_n)
	begin
		if (!arst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign tick = s_q.tick;
	assign cal_clk = s_q.clk;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_div_ratio;
		@(posedge clk_sys) disable iff (!arst_n)
		run && $stable(sel) && s_q.tick |->
			$past(s_q.cnt) == vco_cal_pkg::div_last(sel);
	endproperty
	a_div_ratio: assert property (p_div_ratio) else $error("divided period wrong");

	property p_div16;
		@(posedge clk_sys) disable iff (!arst_n)
		s_q.tick && run && sel == 2'h3 ##1 (run && sel == 2'h3)[*8] |-> !s_q.tick;
	endproperty
	a_div16: assert property (p_div16) else $error("divide by 16 ticked early");
endmodule

// ===== verif/host_model.sv
// Purpose: host on the far side, driving the staged register port
// Assumes: requests launched 1 ns after a rising edge
// Notes: one idle cycle between requests; released data is inverted
`timescale 1ns/100ps
module host_model
(
	input wire logic clk_sys,
	input wire logic [7:0] rd_data,
	output logic wr_en,
	output logic [9:0] wr_addr,
	output logic [7:0] wr_data,
	output logic rd_en,
	output logic [9:0] rd_addr,
	output logic io_update
);
	// idle levels from time zero
	initial
	begin
		{wr_en, rd_en, io_update} = 3'h0;
		wr_addr = 10'h3FF;
		rd_addr = 10'h3FF;
		wr_data = 8'h00;
	end

	// write held for one edge; released data inverted so it is never reused
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_sys) #1;
		{wr_en, wr_addr, wr_data} = {1'b1, a, d};
		@(posedge clk_sys) #1;
		{wr_en, wr_data} = {1'b0, ~d};
	endtask

	// read data is registered, taken one edge after the strobe
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge clk_sys) #1;
		{rd_en, rd_addr} = {1'b1, a};
		@(posedge clk_sys) #1;
		rd_en = 1'b0;
		d = rd_data;
	endtask

	task automatic upd();
		@(posedge clk_sys) #1;
		io_update = 1'b1;
		@(posedge clk_sys) #1;
		io_update = 1'b0;
	endtask

	// trigger order: 0, transfer, 1, transfer
	task automatic cal_start(input logic [1:0] sel);
		wr(vco_cal_pkg::ADDR_CAL_CTRL, {5'h00, sel, 1'b0});
		upd();
		wr(vco_cal_pkg::ADDR_CAL_CTRL, {5'h00, sel, 1'b1});
		upd();
	endtask
endmodule

// ===== verif/tb.sv
// Purpose: self-checking bench for the calibration control block
// Assumes: one 250 MHz clock, reset held for two cycles
// Notes: the full calibration lengths are run, about 2000 cycles
`timescale 1ns/100ps
module tb;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic wr_en, rd_en, io_update, cal_busy, cal_done;
	logic [9:0] wr_addr, rd_addr;
	logic [7:0] rd_data, cal_act, dly_act, d, wr_data;
	int n_mismatch = 0;
	int n_tests = 0;

	always #2 clk_sys = ~clk_sys;

	vco_calibration_control dut (.clk_sys(clk_sys), .arst_n(arst_n), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
		.io_update(io_update), .rd_data(rd_data), .cal_ctrl_active(cal_act),
		.dly_ctrl_active(dly_act), .cal_busy(cal_busy), .cal_done(cal_done), .cal_clk());
	host_model host (.clk_sys(clk_sys), .rd_data(rd_data), .wr_en(wr_en),
		.wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr),
		.io_update(io_update));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		if (n_mismatch == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// reset contents, including an unmapped read
	task automatic t_reset();
		chk({cal_act, dly_act}, 16'h0600);
		host.rd(vco_cal_pkg::ADDR_CAL_CTRL, d);
		chk({8'h00, d}, 16'h0006);
		host.rd(10'h3FF, d);
		chk({8'h00, d}, 16'h0000);
	endtask

	// writes wait in staging until the transfer strobe
	task automatic t_staging();
		host.wr(vco_cal_pkg::ADDR_DLY_CTRL, 8'h2D);
		chk({8'h00, dly_act}, 16'h0000);
		host.rd(vco_cal_pkg::ADDR_DLY_CTRL, d);
		chk({8'h00, d}, 16'h002D);
		host.upd();
		chk({8'h00, dly_act}, 16'h002D);
		chk({15'h0000, cal_busy}, 16'h0000);
	endtask

	// every ratio, busy length counted, one done pulse at the end
	task automatic t_ratios();
		logic [15:0] n;
		for (int s = 0; s < 4; s++)
		begin
			host.cal_start(s[1:0]);
			chk({8'h00, cal_act}, {13'h0000, s[1:0], 1'b1});
			n = 16'h0000;
			while (cal_busy === 1'b1 && n < 16'h0FA0)
			begin
				n++;
				@(posedge clk_sys) #1;
			end
			chk(n, vco_cal_pkg::CAL_TICKS * (16'h0002 << s));
			chk({15'h0000, cal_done}, 16'h0001);
		end
	endtask

	// a bit that stays at 1 across a transfer starts nothing
	task automatic t_hold();
		host.upd();
		repeat (3) @(posedge clk_sys) #1;
		chk({14'h0000, cal_busy, cal_done}, 16'h0000);
	endtask

	initial
	begin
		repeat (2) @(posedge clk_sys);
		#1 arst_n = 1'b1;
		t_reset();
		t_staging();
		t_ratios();
		t_hold();
		print_verdict();
	end

	// watchdog well beyond the 2000 or so cycles of the run
	initial
	begin
		#60000;
		n_mismatch++;
		print_verdict();
	end
endmodule
